// file: rtl/clock_source_selector.sv
// Purpose: clock source selection register and selectors for usb core and system clock
// Assumes: clock sources arrive as levels sampled on clk_in
// Notes:   reserved codes hold the previous valid selection
// Function
// - bit 7 reads zero; writes to it are ignored.
// - bit 3 reads zero; writes ignored; it separates the fields.
// - bits 6..4 pick the usb function core clock.
// - usb codes: x4 mult, int/2, ext/1..ext/4; 110,111 reserved.
// - usb clock should be 48 MHz in full-speed mode.
// - usb clock should be 6 MHz in low-speed mode.
// - bits 2..0 pick system clock: int, ext, x4/2, x4, low-freq.
// - undivided x4 system choice only on 48 MHz rated parts.
// - flash read timing bit should be 0 at 25 MHz or below.
// - flash read timing bit should be 1 above 25 MHz up to 48.
`timescale 1ns/100ps
module clock_source_selector
	import clock_source_select_pkg::*;
#(
	parameter bit FAST_PART = 1'b1
)
(
	// clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	// special-function register port
	input  wire clock_source_select_pkg::sfr_req_t sfr_req_in,
	output logic [7:0]                sfr_rdata_out,
	// raw clock sources
	input  wire logic                 mul4_clk_in,
	input  wire logic                 int_osc_clk_in,
	input  wire logic                 int_osc_div_clk_in,
	input  wire logic                 ext_osc_clk_in,
	input  wire logic                 lf_osc_clk_in,
	// usb speed and flash timing advice
	input  wire logic                 usb_full_speed_in,
	input  wire logic [5:0]           sys_clk_mhz_in,
	input  wire logic [5:0]           usb_clk_mhz_in,
	// selected clocks and advisory flags
	output logic                      usb_core_clk_out,
	output logic                      sys_clk_out,
	output logic                      flash_read_timing_out,
	output logic                      usb_rate_ok_out
);

	logic [7:0] clock_source_select_ff;
	logic [7:0] nxt_clock_source_select;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic [1:0] ext_cnt_ff;
	logic [1:0] nxt_ext_cnt;
	logic [1:0] ext_cnt3_ff;
	logic [1:0] nxt_ext_cnt3;
	logic       ext_prev_ff;
	logic       mul4_prev_ff;
	logic       int_prev_ff;
	logic       mul4_half_ff;
	logic       int_half_ff;
	logic       ext_d2_ff;
	logic       ext_d3_ff;
	logic       ext_d4_ff;
	logic       flash_read_timing_ff;
	logic       rate_ok_ff;
	logic [4:0] src_s1_ff;
	logic [4:0] src_s2_ff;
	logic [2:0] usb_choice;
	logic [2:0] sys_choice;
	clk_src_t   usb_src;
	clk_src_t   sys_src;
	logic       usb_mux_clk;
	logic       sys_mux_clk;
	logic       usb_ok_code;
	logic       sys_ok_code;

	function automatic logic usb_code_valid(input logic [2:0] code);
		usb_code_valid = (code <= USB_EXT_DIV4);
	endfunction : usb_code_valid

	function automatic logic sys_code_valid(input logic [2:0] code, input bit fast);
		sys_code_valid = (code <= SYS_LF_OSC) && (fast || code != SYS_MUL4);
	endfunction : sys_code_valid

	assign usb_choice = clock_source_select_ff[USB_FIELD_LSB +: 3];
	assign sys_choice = clock_source_select_ff[SYS_FIELD_LSB +: 3];
	// judged on the written value, so a refused code never claims a landed write
	assign usb_ok_code = usb_code_valid(sfr_req_in.wdata[USB_FIELD_LSB +: 3]);
	assign sys_ok_code = sys_code_valid(sfr_req_in.wdata[SYS_FIELD_LSB +: 3], FAST_PART);

	// register write: unused bits masked, reserved codes keep the old field
	always_comb
	begin
		nxt_clock_source_select = clock_source_select_ff;
		nxt_rdata = clock_source_select_ff & CLOCK_SOURCE_SELECT_MASK;
		if (sfr_req_in.wr && sfr_req_in.addr == CLOCK_SOURCE_SELECT_ADDR)
		begin
			nxt_clock_source_select = sfr_req_in.wdata & CLOCK_SOURCE_SELECT_MASK;
			if (!usb_code_valid(sfr_req_in.wdata[USB_FIELD_LSB +: 3]))
				nxt_clock_source_select[USB_FIELD_LSB +: 3] = usb_choice;
			if (!sys_code_valid(sfr_req_in.wdata[SYS_FIELD_LSB +: 3], FAST_PART))
				nxt_clock_source_select[SYS_FIELD_LSB +: 3] = sys_choice;
		end
		if (sfr_req_in.addr != CLOCK_SOURCE_SELECT_ADDR)
			nxt_rdata = 8'h00;
	end

	// external oscillator divider: counts rising edges of the synced source
	always_comb
	begin
		nxt_ext_cnt  = ext_cnt_ff;
		nxt_ext_cnt3 = ext_cnt3_ff;
		if (src_s2_ff[3] && !ext_prev_ff)
		begin
			nxt_ext_cnt  = (ext_cnt_ff == 2'h3) ? 2'h0 : 2'(ext_cnt_ff + 2'h1);
			// divide by three needs its own modulo-3 count
			nxt_ext_cnt3 = (ext_cnt3_ff == 2'h2) ? 2'h0 : 2'(ext_cnt3_ff + 2'h1);
		end
	end

	always_ff @(posedge clk_in)
	begin
		src_s1_ff <= {lf_osc_clk_in, ext_osc_clk_in, int_osc_clk_in,
			int_osc_div_clk_in, mul4_clk_in};
		src_s2_ff <= src_s1_ff;
		if (!rst_n_in)
		begin
			clock_source_select_ff <= CLOCK_SOURCE_SELECT_RST;
			rdata_ff     <= 8'h00;
			ext_cnt_ff   <= 2'h0;
			ext_cnt3_ff  <= 2'h0;
			ext_prev_ff  <= 1'b0;
			mul4_prev_ff <= 1'b0;
			int_prev_ff  <= 1'b0;
			mul4_half_ff <= 1'b0;
			int_half_ff  <= 1'b0;
			ext_d2_ff    <= 1'b0;
			ext_d3_ff    <= 1'b0;
			ext_d4_ff    <= 1'b0;
			flash_read_timing_ff      <= 1'b0;
			rate_ok_ff   <= 1'b0;
		end
		else
		begin
			clock_source_select_ff <= nxt_clock_source_select;
			rdata_ff     <= nxt_rdata;
			ext_cnt_ff   <= nxt_ext_cnt;
			ext_cnt3_ff  <= nxt_ext_cnt3;
			ext_prev_ff  <= src_s2_ff[3];
			mul4_prev_ff <= src_s2_ff[0];
			int_prev_ff  <= src_s2_ff[2];
			if (src_s2_ff[0] && !mul4_prev_ff)
				mul4_half_ff <= !mul4_half_ff;
			if (src_s2_ff[2] && !int_prev_ff)
				int_half_ff <= !int_half_ff;
			if (src_s2_ff[3] && !ext_prev_ff)
			begin
				ext_d2_ff <= !ext_d2_ff;
				ext_d3_ff <= (ext_cnt3_ff == 2'h0);
				ext_d4_ff <= (ext_cnt_ff == 2'h1) ? !ext_d4_ff :
					((ext_cnt_ff == 2'h3) ? !ext_d4_ff : ext_d4_ff);
			end
			// advisory flash timing follows the system clock rate
			flash_read_timing_ff <= (sys_clk_mhz_in > 6'(FLASH_FAST_MHZ));
			rate_ok_ff <= usb_full_speed_in ? (usb_clk_mhz_in == 6'(USB_FS_MHZ))
				: (usb_clk_mhz_in == 6'(USB_LS_MHZ));
		end
	end

	// source tables; unused entries stay low so a stray grant only stops the clock
	always_comb
	begin
		usb_src.src = '0;
		usb_src.src[USB_MUL4]     = src_s2_ff[0];
		usb_src.src[USB_INT_DIV2] = int_half_ff;
		usb_src.src[USB_EXT_DIV1] = src_s2_ff[3];
		usb_src.src[USB_EXT_DIV2] = ext_d2_ff;
		usb_src.src[USB_EXT_DIV3] = ext_d3_ff;
		usb_src.src[USB_EXT_DIV4] = ext_d4_ff;
		sys_src.src = '0;
		sys_src.src[SYS_INT_OSC]   = src_s2_ff[1];
		sys_src.src[SYS_EXT_OSC]   = src_s2_ff[3];
		sys_src.src[SYS_MUL4_DIV2] = mul4_half_ff;
		sys_src.src[SYS_MUL4]      = FAST_PART ? src_s2_ff[0] : 1'b0;
		sys_src.src[SYS_LF_OSC]    = src_s2_ff[4];
	end

	glitch_free_mux u_usb_mux (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.sel_in    (usb_choice),
		.src_in    (usb_src),
		.clk_out   (usb_mux_clk),
		.grant_out ()
	);

	glitch_free_mux u_sys_mux (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.sel_in    (sys_choice),
		.src_in    (sys_src),
		.clk_out   (sys_mux_clk),
		.grant_out ()
	);

	assign sfr_rdata_out         = rdata_ff;
	assign usb_core_clk_out      = usb_mux_clk;
	assign sys_clk_out           = sys_mux_clk;
	assign flash_read_timing_out = flash_read_timing_ff;
	assign usb_rate_ok_out       = rate_ok_ff;

	AST_TOP_BIT_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!sfr_rdata_out[7]) else $error("bit 7 read nonzero");
	AST_BIT3_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!clock_source_select_ff[3]) else $error("bit 3 stored nonzero");
	AST_USB_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sfr_req_in.wr && sfr_req_in.addr == CLOCK_SOURCE_SELECT_ADDR && usb_ok_code
		|=> usb_choice == $past(sfr_req_in.wdata[6:4]))
		else $error("usb field not written");
	AST_USB_RESERVED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		usb_choice <= USB_EXT_DIV4) else $error("reserved usb code held");
	AST_SYS_RESERVED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sys_choice <= SYS_LF_OSC) else $error("reserved system code held");
	AST_SYS_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sfr_req_in.wr && sfr_req_in.addr == CLOCK_SOURCE_SELECT_ADDR && sys_ok_code
		|=> sys_choice == $past(sfr_req_in.wdata[2:0]))
		else $error("system field not written");
	AST_MUL4_GATED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!FAST_PART |-> sys_choice != SYS_MUL4) else $error("x4 on slow part");
	AST_FLASH_TIMING: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		##1 flash_read_timing_out == ($past(sys_clk_mhz_in) > 6'(FLASH_FAST_MHZ)))
		else $error("flash timing mismatch");
	AST_READBACK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sfr_req_in.addr == CLOCK_SOURCE_SELECT_ADDR
		|=> sfr_rdata_out == ($past(clock_source_select_ff) & CLOCK_SOURCE_SELECT_MASK))
		else $error("readback wrong");

endmodule : clock_source_selector

// file: common/clock_source_select_pkg.sv
// Purpose: shared constants and types for the clock source selector
// Assumes: 8-bit special-function register port from the processor core
// Notes:   all field positions, codes and reset values live here
package clock_source_select_pkg;

	localparam logic [7:0] CLOCK_SOURCE_SELECT_ADDR = 8'hA9;
	localparam logic [7:0] CLOCK_SOURCE_SELECT_RST  = 8'h00;
	localparam logic [7:0] CLOCK_SOURCE_SELECT_MASK = 8'h77;
	localparam int         USB_FIELD_LSB            = 4;
	localparam int         SYS_FIELD_LSB            = 0;

	// usb core clock choice codes
	localparam logic [2:0] USB_MUL4      = 3'h0;
	localparam logic [2:0] USB_INT_DIV2  = 3'h1;
	localparam logic [2:0] USB_EXT_DIV1  = 3'h2;
	localparam logic [2:0] USB_EXT_DIV2  = 3'h3;
	localparam logic [2:0] USB_EXT_DIV3  = 3'h4;
	localparam logic [2:0] USB_EXT_DIV4  = 3'h5;

	// system clock choice codes
	localparam logic [2:0] SYS_INT_OSC   = 3'h0;
	localparam logic [2:0] SYS_EXT_OSC   = 3'h1;
	localparam logic [2:0] SYS_MUL4_DIV2 = 3'h2;
	localparam logic [2:0] SYS_MUL4      = 3'h3;
	localparam logic [2:0] SYS_LF_OSC    = 3'h4;

	// source index for the glitch-free selector
	localparam int         NUM_SRC       = 8;
	localparam logic [7:0] SRC_RST_ONEHOT = 8'h01;

	// frequency thresholds in MHz
	localparam int         FLASH_FAST_MHZ = 25;
	localparam int         USB_FS_MHZ     = 48;
	localparam int         USB_LS_MHZ     = 6;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
	} sfr_req_t;

	typedef struct packed {
		logic [NUM_SRC-1:0] src;
	} clk_src_t;

endpackage : clock_source_select_pkg

// file: rtl/glitch_free_mux.sv
// Purpose: glitch-free N-way clock selector
// Assumes: each source is sampled on clk_in, so sources are slower than clk_in/2
// Notes:   break-before-make: the old grant drops before the new one rises
`timescale 1ns/100ps
module glitch_free_mux
	import clock_source_select_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	// selection
	input  wire logic [2:0]           sel_in,
	input  wire clock_source_select_pkg::clk_src_t src_in,
	// output
	output logic                      clk_out,
	output logic [NUM_SRC-1:0]        grant_out
);

	logic [NUM_SRC-1:0] src_s1_ff;
	logic [NUM_SRC-1:0] src_s2_ff;
	logic [NUM_SRC-1:0] grant_ff;
	logic [NUM_SRC-1:0] nxt_grant;
	logic               clk_ff;
	logic               nxt_clk;

	function automatic logic [NUM_SRC-1:0] onehot(input logic [2:0] idx);
		onehot = SRC_RST_ONEHOT << idx;
	endfunction : onehot

	// grant changes only while the outgoing source is low, so no runt pulse
	always_comb
	begin
		nxt_grant = grant_ff;
		if (grant_ff != onehot(sel_in))
		begin
			if (grant_ff == '0)
				nxt_grant = onehot(sel_in);
			else if ((grant_ff & src_s2_ff) == '0)
				nxt_grant = '0;
		end
		nxt_clk = |(grant_ff & src_s2_ff);
	end

	always_ff @(posedge clk_in)
	begin
		src_s1_ff <= src_in.src;
		src_s2_ff <= src_s1_ff;
		if (!rst_n_in)
		begin
			grant_ff <= SRC_RST_ONEHOT;
			clk_ff   <= 1'b0;
		end
		else
		begin
			grant_ff <= nxt_grant;
			clk_ff   <= nxt_clk;
		end
	end

	assign clk_out   = clk_ff;
	assign grant_out = grant_ff;

	AST_ONE_GRANT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$onehot0(grant_ff)) else $error("more than one clock granted");
	AST_NO_RUNT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(grant_ff != $past(grant_ff)) && ($past(grant_ff) != '0) |-> !clk_ff)
		else $error("grant dropped while clock high");

endmodule : glitch_free_mux

// file: tb/clock_source_selector_test.sv
// Purpose: self-checking bench for the clock source selector
// Assumes: sources are toggled slowly enough to be sampled on clk_in
// Notes:   edge counts allow a small slack because selector switching and sync add lag
`timescale 1ns/100ps
module clock_source_selector_test;
	import clock_source_select_pkg::*;

	logic       clk_in = 1'b0;
	logic       rst_n_in = 1'b0;
	sfr_req_t   req = '0;
	logic [7:0] rdata;
	logic       mul4_clk = 1'b0, int_clk = 1'b0, int_div_clk = 1'b0, ext_clk = 1'b0, lf_clk = 1'b0;
	logic       full_speed = 1'b0;
	logic [5:0] sys_mhz = 6'h00, usb_mhz = 6'h00;
	logic       usb_clk, sys_clk, flash_rt, rate_ok, usb_prev, sys_prev;
	int         failures = 0, checks_done = 0, cyc = 0, usb_rises = 0, sys_rises = 0;
	int         seed = 54827;
	int         mu = 0, ms = 0;
	int         uh[6] = '{2, 6, 5, 10, 15, 20};
	int         sh[5] = '{3, 5, 4, 2, 7};

	clock_source_selector uut (
		.clk_in                (clk_in),
		.rst_n_in              (rst_n_in),
		.sfr_req_in            (req),
		.sfr_rdata_out         (rdata),
		.mul4_clk_in           (mul4_clk),
		.int_osc_clk_in        (int_clk),
		.int_osc_div_clk_in    (int_div_clk),
		.ext_osc_clk_in        (ext_clk),
		.lf_osc_clk_in         (lf_clk),
		.usb_full_speed_in     (full_speed),
		.sys_clk_mhz_in        (sys_mhz),
		.usb_clk_mhz_in        (usb_mhz),
		.usb_core_clk_out      (usb_clk),
		.sys_clk_out           (sys_clk),
		.flash_read_timing_out (flash_rt),
		.usb_rate_ok_out       (rate_ok)
	);

	always #20 clk_in = ~clk_in;

	// each source except int_div_clk, which shares int_clk's half period, has a distinct half period so a wrong pick shows in the edge count
	always @(posedge clk_in)
	begin
		#1;
		cyc++;
		mul4_clk = (cyc / 2) % 2;
		int_clk = (cyc / 3) % 2;
		int_div_clk = (cyc / 3) % 2;
		ext_clk = (cyc / 5) % 2;
		lf_clk = (cyc / 7) % 2;
	end

	always @(posedge clk_in)
	begin
		if (usb_clk === 1'b1 && usb_prev === 1'b0) usb_rises++;
		if (sys_clk === 1'b1 && sys_prev === 1'b0) sys_rises++;
		usb_prev = usb_clk;
		sys_prev = sys_clk;
	end

	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// model keeps the old field when a reserved code is written; code 3 counts as valid for the system field
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1 req = '{addr: a, wdata: d, wr: 1'b1};
		@(posedge clk_in);
		#1 req.wr = 1'b0;
		if (a == CLOCK_SOURCE_SELECT_ADDR)
		begin
			if (d[6:4] < 3'h6) mu = d[6:4];
			if (d[2:0] < 3'h5) ms = d[2:0];
		end
	endtask : sfr_write

	task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
		req.addr = a;
		@(posedge clk_in);
		#1 check(rdata, exp);
	endtask : sfr_read

	task automatic count_close(input int seen, input int exp);
		check((seen - exp <= 2 && exp - seen <= 2), 1);
	endtask : count_close

	initial
	begin
		#(40 * 20000);
		failures++;
		$display("watchdog expired");
		results();
	end

	initial
	begin
		logic [7:0] v;
		repeat (8) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		sfr_read(CLOCK_SOURCE_SELECT_ADDR, CLOCK_SOURCE_SELECT_RST);
		$display("test reset value done");
		for (int i = 0; i < 40; i++)
		begin
			v = 8'($random(seed));
			sfr_write(CLOCK_SOURCE_SELECT_ADDR, v);
			sfr_read(CLOCK_SOURCE_SELECT_ADDR, 8'((mu << 4) | ms));
		end
		v = 8'($random(seed));
		sfr_write(8'hA8, v);
		sfr_read(CLOCK_SOURCE_SELECT_ADDR, 8'((mu << 4) | ms));
		sfr_read(8'hA8, 8'h00);
		$display("test register access done");
		for (int i = 0; i < 30; i++)
		begin
			sys_mhz = 6'($random(seed));
			full_speed = 1'($random(seed));
			v = 8'($random(seed));
			usb_mhz = (v[1:0] == 2'h0) ? 6'h06 : (v[1:0] == 2'h1) ? 6'h30 : v[7:2];
			repeat (2) @(posedge clk_in);
			#1 check(flash_rt, (sys_mhz > 25));
			check(rate_ok, full_speed ? (usb_mhz == 48) : (usb_mhz == 6));
		end
		$display("test advisory flags done");
		for (int i = 0; i < 6; i++)
		begin
			sfr_write(CLOCK_SOURCE_SELECT_ADDR, 8'((i << 4) | (i % 5)));
			repeat (60) @(posedge clk_in);
			#1 usb_rises = 0;
			sys_rises = 0;
			repeat (480) @(posedge clk_in);
			#1 count_close(usb_rises, 480 / (2 * uh[mu]));
			count_close(sys_rises, 480 / (2 * sh[ms]));
		end
		$display("test clock selection done");
		results();
	end
endmodule : clock_source_selector_test
